//--- dv/rpps_host_model.sv
// Host side of the register access port: byte read and write tasks.
// Assumes the device answers a read with reg_rvalid two cycles after the request edge.
`timescale 1ns/10ps
module rpps_host_model (
  // Clock and answer
  input  wire logic       clk,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  // Requests
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  localparam time DRV_DLY = 1ns;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #DRV_DLY;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #DRV_DLY;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Callers read RAM only where they wrote first
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(posedge clk);
    #DRV_DLY;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #DRV_DLY;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 3; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge clk);
      #DRV_DLY;
    end
  endtask : rd
endmodule : rpps_host_model

//--- dv/tb_top.sv
// Self-checking bench for the RAM paging and pin status block.
// Assumes rpps_top and the host model; pins and comparator are driven here.
`timescale 1ns/10ps
module tb_top;
  import rpps_pkg::*;
  localparam time DRV_DLY = 1ns;

  logic       clk      = 1'b0;
  logic       reset    = 1'b1;
  logic       spi_mode = 1'b0;
  logic       wdog     = 1'b0;
  logic       ext      = 1'b0;
  logic       vbat     = 1'b1;
  logic       bclr     = 1'b0;
  logic       reg_wr, reg_rd, reg_rvalid, flag, pol;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [5:0] ofs;
  int         error_cnt = 0;
  int         tests_run = 0;

  always #10 clk = ~clk;

  rpps_host_model i_host (.clk(clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  rpps_top i_dut (.clk(clk), .reset(reset), .spi_mode(spi_mode), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .watchdog_input_pin(wdog), .external_interrupt_pin(ext),
    .vbat_above_ref(vbat), .battery_flag_clear(bclr), .battery_low_flag(flag),
    .battery_flag_polarity(pol));

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #DRV_DLY;
  endtask : step

  initial begin
    #100us;
    error_cnt++;
    give_verdict();
  end

  initial begin
    step(6);
    reset = 1'b0;
    check("flag_idle", {7'h00, flag}, 8'h00);
    vbat = 1'b0;
    step(6);
    check("flag_fall", {7'h00, flag}, 8'h01);
    bclr = 1'b1;
    step(1);
    bclr = 1'b0;
    step(2);
    check("flag_clear", {7'h00, flag}, 8'h00);
    i_host.wr(RPPS_PAGE_REG_ADDR, 8'h40);
    step(2);
    check("polarity", {7'h00, pol}, 8'h01);
    vbat = 1'b1;
    step(6);
    check("flag_rise", {7'h00, flag}, 8'h01);
    // Falling is no event under this polarity, so the clear holds
    vbat = 1'b0;
    bclr = 1'b1;
    step(4);
    check("flag_fall_ignored", {7'h00, flag}, 8'h00);
    // Clear pulse lands on the rising crossing edge: set must win
    bclr = 1'b0;
    vbat = 1'b1;
    step(2);
    bclr = 1'b1;
    step(1);
    bclr = 1'b0;
    step(2);
    check("set_wins", {7'h00, flag}, 8'h01);
    wdog = 1'b1;
    step(3);
    i_host.rd(RPPS_PAGE_REG_ADDR, rv);
    check("page_wdog", rv, 8'h60);
    wdog = 1'b0;
    ext  = 1'b1;
    step(3);
    i_host.rd(RPPS_PAGE_REG_ADDR, rv);
    check("page_ext", rv, 8'h50);
    ext = 1'b0;
    step(3);
    i_host.wr(RPPS_PAGE_REG_ADDR, 8'hFF);
    i_host.rd(RPPS_PAGE_REG_ADDR, rv);
    check("page_all", rv, 8'h47);
    // Each page writes through the standard window, read back through both windows
    for (int p = 0; p < 4; p++) begin
      ofs = 6'h2A ^ 6'(p);
      i_host.wr(RPPS_PAGE_REG_ADDR, {5'h00, p[1], p[1:0]});
      i_host.wr({2'b01, ofs}, 8'hA0 + 8'(p));
    end
    for (int p = 0; p < 4; p++) begin
      ofs = 6'h2A ^ 6'(p);
      i_host.wr(RPPS_PAGE_REG_ADDR, {5'h00, p[1], p[1:0]});
      i_host.rd({1'b1, p[0], ofs}, rv);
      check("alt_alias", rv, 8'hA0 + 8'(p));
      i_host.rd({2'b01, ofs}, rv);
      check("std_read", rv, 8'hA0 + 8'(p));
    end
    i_host.wr(RPPS_PAGE_REG_ADDR, 8'h00);
    spi_mode = 1'b1;
    i_host.wr(8'hAA, 8'h55);
    i_host.rd(8'hAA, rv);
    check("spi_alt_read", rv, RPPS_READ_NONE);
    i_host.rd(8'h6A, rv);
    check("spi_std_read", rv, 8'hA0);
    spi_mode = 1'b0;
    i_host.rd(8'hAA, rv);
    check("spi_alt_write", rv, 8'hA0);
    i_host.rd(8'h20, rv);
    check("unmapped", rv, RPPS_READ_NONE);
    i_host.wr(RPPS_PAGE_REG_ADDR, 8'h47);
    i_host.rd(RPPS_PAGE_REG_ADDR, rv);
    check("page_pre_reset", rv, 8'h47);
    reset = 1'b1;
    step(3);
    reset = 1'b0;
    check("rdata_reset", reg_rdata, RPPS_READ_NONE);
    check("flag_reset", {7'h00, flag}, 8'h00);
    check("pol_reset", {7'h00, pol}, 8'h00);
    i_host.rd(RPPS_PAGE_REG_ADDR, rv);
    check("page_reset", rv, 8'h00);
    i_host.rd(8'hAA, rv);
    check("ram_kept", rv, 8'hA0);
    give_verdict();
  end
endmodule : tb_top

//--- shared/rpps_pkg.sv
// Package for the RAM paging and pin status block: register map, field positions, reset values.
// Assumes an 8-bit register address space with byte-wide data.
package rpps_pkg;

  localparam logic [7:0] RPPS_PAGE_REG_ADDR = 8'h3F;
  localparam logic [7:0] RPPS_STD_BASE      = 8'h40;
  localparam logic [7:0] RPPS_STD_LAST      = 8'h7F;
  localparam logic [7:0] RPPS_ALT_BASE      = 8'h80;
  localparam logic [7:0] RPPS_ALT_LAST      = 8'hFF;

  localparam int RPPS_POL_BIT      = 6;
  localparam int RPPS_WDOG_BIT     = 5;
  localparam int RPPS_EXT_BIT      = 4;
  localparam int RPPS_ALT_PAGE_BIT = 2;
  localparam int RPPS_STD_PAGE_HI  = 1;
  localparam int RPPS_STD_PAGE_LO  = 0;

  localparam int RPPS_STD_OFS_BITS = 6;
  localparam int RPPS_ALT_OFS_BITS = 7;
  localparam int RPPS_RAM_DEPTH    = 256;

  localparam logic       RPPS_POL_RESET      = 1'b0;
  localparam logic       RPPS_ALT_PAGE_RESET = 1'b0;
  localparam logic [1:0] RPPS_STD_PAGE_RESET = 2'h0;
  localparam logic [7:0] RPPS_READ_NONE      = 8'h00;

  typedef enum logic [1:0] {
    RPPS_WIN_NONE,
    RPPS_WIN_STD,
    RPPS_WIN_ALT
  } rpps_window_type;

endpackage : rpps_pkg

//--- src/rpps_ram.sv
// Byte-wide 256-entry RAM behind the two paged windows.
// Assumes one access per cycle; contents are never initialised.
`timescale 1ns/10ps
module rpps_ram
  import rpps_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Access
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [RPPS_RAM_DEPTH];

  // No reset port: the array holds whatever it had, including across battery operation
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule : rpps_ram

//--- src/rpps_top.sv
// RAM paging control register, pin level status and paged RAM windows.
// Assumes a host serial front end that presents byte accesses on reg_addr with one-cycle
// strobes, and an analog comparator result for the battery-versus-threshold compare.
// Functional notes
// [RULE_01] Polarity bit 6 clear flags battery low on falling below the threshold, set flags it on rising above.
// [RULE_02] Bit 5 is read-only and returns the present watchdog input pin level.
// [RULE_03] Bit 4 is read-only and returns the present external interrupt pin level.
// [RULE_04] Bit 2 is a writable page bit used as the top RAM address bit for alternate window accesses.
// [RULE_05] Bits 1:0 are a writable page field used as the top two RAM address bits for standard window accesses.
// [RULE_06] Offsets 0x40 to 0x7F form a 64-byte standard window usable in both interface modes.
// [RULE_07] A standard access addresses RAM with the page field over the low 6 offset bits.
// [RULE_08] Offsets 0x80 to 0xFF form a 128-byte alternate window reachable only in the two-wire mode.
// [RULE_09] An alternate access addresses RAM with the page bit over the low 7 offset bits.
// [RULE_10] RAM contents are kept unchanged while running from the backup battery.
// [RULE_11] The host must write RAM before relying on it, since it is never initialised.
// [RULE_12] Reserved bits 7 and 3 read as zero and ignore writes.
`timescale 1ns/10ps
module rpps_top
  import rpps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register access from the serial front end
  input  wire logic       spi_mode,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Pins and analog status
  input  wire logic       watchdog_input_pin,
  input  wire logic       external_interrupt_pin,
  input  wire logic       vbat_above_ref,
  input  wire logic       battery_flag_clear,
  // Status out
  output logic            battery_low_flag,
  output logic            battery_flag_polarity
);

  logic       alt_ram_page_bit_q;
  logic [1:0] std_ram_page_bits_q;
  logic       pol_q;
  logic [1:0] wdog_sync_q;
  logic [1:0] ext_sync_q;
  logic [1:0] vbat_sync_q;
  logic       vbat_prev_q;
  logic       battery_low_flag_q;
  logic       watchdog_pin_level;
  logic       ext_input_pin_level;
  logic       bat_event;

  rpps_window_type win;
  logic [7:0]      ram_addr;
  logic            ram_wr;
  logic [7:0]      ram_rdata;
  logic [7:0]      page_rdata;
  rpps_window_type rd_win_q;
  logic [7:0]      page_rdata_q;
  logic            rd_pend_q;

  function automatic rpps_window_type decode_window(input logic [7:0] a, input logic spi);
    if (a >= RPPS_STD_BASE && a <= RPPS_STD_LAST) begin
      decode_window = RPPS_WIN_STD;
    end else if (a >= RPPS_ALT_BASE && !spi) begin
      decode_window = RPPS_WIN_ALT;
    end else begin
      decode_window = RPPS_WIN_NONE;
    end
  endfunction : decode_window

  // Pins come from outside the clock domain
  always_ff @(posedge clk) begin
    wdog_sync_q <= {wdog_sync_q[0], watchdog_input_pin};
    ext_sync_q  <= {ext_sync_q[0], external_interrupt_pin};
    vbat_sync_q <= {vbat_sync_q[0], vbat_above_ref};
  end

  assign watchdog_pin_level  = wdog_sync_q[1];
  assign ext_input_pin_level = ext_sync_q[1];

  always_ff @(posedge clk) begin
    if (reset) begin
      pol_q               <= RPPS_POL_RESET;
      alt_ram_page_bit_q  <= RPPS_ALT_PAGE_RESET;
      std_ram_page_bits_q <= RPPS_STD_PAGE_RESET;
    end else if (reg_wr && reg_addr == RPPS_PAGE_REG_ADDR) begin
      pol_q               <= reg_wdata[RPPS_POL_BIT];
      alt_ram_page_bit_q  <= reg_wdata[RPPS_ALT_PAGE_BIT];                       // see [RULE_04]
      std_ram_page_bits_q <= reg_wdata[RPPS_STD_PAGE_HI:RPPS_STD_PAGE_LO];       // see [RULE_05]
    end
  end

  // Comparator crossing in the selected direction sets the flag; set beats clear
  assign bat_event = pol_q ? (vbat_sync_q[1] && !vbat_prev_q)
                           : (!vbat_sync_q[1] && vbat_prev_q);                   // see [RULE_01]

  always_ff @(posedge clk) begin
    if (reset) begin
      vbat_prev_q        <= 1'b0;
      battery_low_flag_q <= 1'b0;
    end else begin
      vbat_prev_q <= vbat_sync_q[1];
      if (bat_event) begin
        battery_low_flag_q <= 1'b1;                                              // see [RULE_01]
      end else if (battery_flag_clear) begin
        battery_low_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      battery_low_flag      <= 1'b0;
      battery_flag_polarity <= RPPS_POL_RESET;
    end else begin
      battery_low_flag      <= battery_low_flag_q;
      battery_flag_polarity <= pol_q;
    end
  end

  always_comb begin
    win = decode_window(reg_addr, spi_mode);                                     // see [RULE_08]
    case (win)
      RPPS_WIN_STD: ram_addr = {std_ram_page_bits_q,
                                reg_addr[RPPS_STD_OFS_BITS-1:0]};                // see [RULE_07]
      RPPS_WIN_ALT: ram_addr = {alt_ram_page_bit_q,
                                reg_addr[RPPS_ALT_OFS_BITS-1:0]};                // see [RULE_09]
      default:      ram_addr = 8'h00;
    endcase
    ram_wr = reg_wr && (win != RPPS_WIN_NONE);                                   // see [RULE_06]
  end

  // Reserved bits 7 and 3 fixed at zero
  assign page_rdata = {1'b0, pol_q, watchdog_pin_level, ext_input_pin_level,
                       1'b0, alt_ram_page_bit_q, std_ram_page_bits_q};           // see [RULE_12]

  // RAM has no reset, so contents survive reset and battery running
  rpps_ram u_ram (                                                               // see [RULE_10]
    .clk     (clk),
    .wr_en   (ram_wr),
    .addr    (ram_addr),
    .wr_data (reg_wdata),
    .rd_data (ram_rdata)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_pend_q    <= 1'b0;
      rd_win_q     <= RPPS_WIN_NONE;
      page_rdata_q <= RPPS_READ_NONE;
    end else begin
      rd_pend_q    <= reg_rd;
      rd_win_q     <= decode_window(reg_addr, spi_mode);
      page_rdata_q <= (reg_addr == RPPS_PAGE_REG_ADDR) ? page_rdata          // see [RULE_02]
                                                       : RPPS_READ_NONE;     // see [RULE_03]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata  <= RPPS_READ_NONE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_q;
      if (rd_pend_q) begin
        reg_rdata <= (rd_win_q != RPPS_WIN_NONE) ? ram_rdata : page_rdata_q;
      end
    end
  end

  // Assertions
  sequence s_page_write;
    reg_wr && reg_addr == RPPS_PAGE_REG_ADDR;
  endsequence

  sequence s_page_read;
    reg_rd && reg_addr == RPPS_PAGE_REG_ADDR;
  endsequence

  a_pol_follows_write: assert property (@(posedge clk) disable iff (reset) // see [RULE_01]
    s_page_write |=> ##1 battery_flag_polarity == $past(reg_wdata[RPPS_POL_BIT], 2))
    else $error("polarity output does not follow write");

  a_fall_sets_flag: assert property (@(posedge clk) disable iff (reset)   // see [RULE_01]
    (!pol_q && vbat_prev_q && !vbat_sync_q[1]) |=> ##1 battery_low_flag)
    else $error("falling crossing did not raise flag");

  a_rise_sets_flag: assert property (@(posedge clk) disable iff (reset)   // see [RULE_01]
    (pol_q && !vbat_prev_q && vbat_sync_q[1]) |=> ##1 battery_low_flag)
    else $error("rising crossing did not raise flag");

  a_wdog_level_read: assert property (@(posedge clk) disable iff (reset)  // see [RULE_02]
    s_page_read |=> ##1 reg_rdata[RPPS_WDOG_BIT] == $past(watchdog_pin_level, 2))
    else $error("watchdog level bit wrong");

  a_ext_level_read: assert property (@(posedge clk) disable iff (reset)   // see [RULE_03]
    s_page_read |=> ##1 reg_rdata[RPPS_EXT_BIT] == $past(ext_input_pin_level, 2))
    else $error("external pin level bit wrong");

  a_alt_addr_form: assert property (@(posedge clk) disable iff (reset)    // see [RULE_04]
    (reg_addr[7] && !spi_mode) |-> ram_addr[7] == alt_ram_page_bit_q)
    else $error("alternate page bit not used");

  a_std_addr_form: assert property (@(posedge clk) disable iff (reset)    // see [RULE_07]
    (reg_addr[7:6] == 2'h1) |-> ram_addr == {std_ram_page_bits_q, reg_addr[5:0]})
    else $error("standard address wrong");

  a_alt_low_bits: assert property (@(posedge clk) disable iff (reset)     // see [RULE_09]
    (reg_addr[7] && !spi_mode) |-> ram_addr[6:0] == reg_addr[6:0])
    else $error("alternate offset bits wrong");

  a_spi_alt_blocked: assert property (@(posedge clk) disable iff (reset)  // see [RULE_08]
    (spi_mode && reg_addr[7]) |-> !ram_wr)
    else $error("alternate window written in spi mode");

  a_std_write_ok: assert property (@(posedge clk) disable iff (reset)     // see [RULE_06]
    (reg_wr && reg_addr[7:6] == 2'h1) |-> ram_wr)
    else $error("standard window write dropped");

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)    // see [RULE_12]
    s_page_read |=> ##1 (reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0))
    else $error("reserved bits not zero");

  sequence s_read_answer;
    ##1 reg_rvalid;
  endsequence

  a_rvalid_timing: assert property (@(posedge clk) disable iff (reset)    // see [RULE_06]
    reg_rd |=> s_read_answer)
    else $error("read answer not two cycles after request");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (reset)     // see [RULE_06]
    reg_rvalid |-> $past(reg_rd, 2))
    else $error("read valid without a request");

  a_rdata_holds: assert property (@(posedge clk) disable iff (reset)      // see [RULE_06]
    !rd_pend_q |=> $stable(reg_rdata))
    else $error("read data changed without an answer");

  a_std_rd_win: assert property (@(posedge clk) disable iff (reset)       // see [RULE_06]
    (reg_rd && reg_addr[7:6] == 2'h1) |=> rd_win_q == RPPS_WIN_STD)
    else $error("standard window read not decoded");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)    // see [RULE_06]
    (reg_rd && reg_addr < RPPS_PAGE_REG_ADDR) |=> ##1 reg_rdata == RPPS_READ_NONE)
    else $error("unmapped read not zero");

  a_unmapped_no_write: assert property (@(posedge clk) disable iff (reset) // see [RULE_06]
    (win == RPPS_WIN_NONE) |-> !ram_wr)
    else $error("ram written outside the windows");

  a_alt_write_ok: assert property (@(posedge clk) disable iff (reset)     // see [RULE_08]
    (reg_wr && reg_addr[7] && !spi_mode) |-> ram_wr)
    else $error("alternate window write dropped");

  a_alt_rd_win: assert property (@(posedge clk) disable iff (reset)       // see [RULE_08]
    (reg_rd && reg_addr[7] && !spi_mode) |=> rd_win_q == RPPS_WIN_ALT)
    else $error("alternate window read not decoded");

  a_spi_alt_zero: assert property (@(posedge clk) disable iff (reset)     // see [RULE_08]
    (reg_rd && reg_addr[7] && spi_mode) |=> ##1 reg_rdata == RPPS_READ_NONE)
    else $error("alternate window read in spi mode not zero");

  a_alt_page_write: assert property (@(posedge clk) disable iff (reset)   // see [RULE_04]
    s_page_write |=> alt_ram_page_bit_q == $past(reg_wdata[RPPS_ALT_PAGE_BIT]))
    else $error("alternate page bit not written");

  a_alt_page_hold: assert property (@(posedge clk) disable iff (reset)    // see [RULE_04]
    !(reg_wr && reg_addr == RPPS_PAGE_REG_ADDR) |=> $stable(alt_ram_page_bit_q))
    else $error("alternate page bit changed without a write");

  a_std_page_write: assert property (@(posedge clk) disable iff (reset)   // see [RULE_05]
    s_page_write |=> std_ram_page_bits_q ==
                     $past(reg_wdata[RPPS_STD_PAGE_HI:RPPS_STD_PAGE_LO]))
    else $error("standard page field not written");

  a_std_page_hold: assert property (@(posedge clk) disable iff (reset)    // see [RULE_05]
    !(reg_wr && reg_addr == RPPS_PAGE_REG_ADDR) |=> $stable(std_ram_page_bits_q))
    else $error("standard page field changed without a write");

  a_reset_values: assert property (@(posedge clk)                         // see [RULE_05]
    reset |=> (!reg_rvalid && reg_rdata == RPPS_READ_NONE && !battery_low_flag &&
               battery_flag_polarity == RPPS_POL_RESET &&
               alt_ram_page_bit_q == RPPS_ALT_PAGE_RESET &&
               std_ram_page_bits_q == RPPS_STD_PAGE_RESET))
    else $error("reset values wrong");

  a_pol_reg_write: assert property (@(posedge clk) disable iff (reset)    // see [RULE_01]
    s_page_write |=> pol_q == $past(reg_wdata[RPPS_POL_BIT]))
    else $error("polarity bit not written");

  a_pol_out_copy: assert property (@(posedge clk) disable iff (reset)     // see [RULE_01]
    1'b1 |=> battery_flag_polarity == $past(pol_q))
    else $error("polarity output does not copy the register");

  a_flag_out_copy: assert property (@(posedge clk) disable iff (reset)    // see [RULE_01]
    1'b1 |=> battery_low_flag == $past(battery_low_flag_q))
    else $error("flag output does not copy the flag");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (reset)  // see [RULE_01]
    (bat_event && battery_flag_clear) |=> battery_low_flag_q)
    else $error("clear won over a crossing");

  a_clear_drops_flag: assert property (@(posedge clk) disable iff (reset) // see [RULE_01]
    (battery_flag_clear && !bat_event) |=> !battery_low_flag_q)
    else $error("clear did not drop flag");

  a_flag_holds: assert property (@(posedge clk) disable iff (reset)       // see [RULE_01]
    (battery_low_flag_q && !battery_flag_clear) |=> battery_low_flag_q)
    else $error("flag dropped without a clear");

  a_no_false_flag: assert property (@(posedge clk) disable iff (reset)    // see [RULE_01]
    (!battery_low_flag_q && !bat_event) |=> !battery_low_flag_q)
    else $error("flag raised without a crossing");

endmodule : rpps_top
